// ==== rtl/break_condition_control.sv ====
// Purpose: channel B cycle qualifier, break control and break issue
// Assumes: comparators outside give address, data, asid and channel A hits
// Notes: APB slave, one wait state on every transfer
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - qualifier register is 8 bits, read/write, zero after reset
// - qualifier bits 31 to 8 always read zero
// - master select: 00 ignore, bit6 set cpu, 10 dma
// - access select: 00 ignore, 01 fetch, 10 data, 11 either
// - direction select: 00 ignore, 01 read, 10 write, 11 either
// - size select: 00 ignore, 01 byte, 10 word, 11 longword
// - control register is 32 bits, read/write, zero after reset
// - control bits 31 to 22 read zero; software writes zero there
// - only bits 21,20,15-10,7,6,3,0 writable; others read zero
// - bit 21 decides whether channel A asid joins its condition
// - channels act independently or as one sequence
// - fetch break taken before or after execution, per channel
// - an enable adds the data bus to channel B
// - enables for pc trace and for execution count break
// - asid mask 0 checks that channel's asid, 1 skips it
// - four match flags set on match, held until software writes 0
// - sequence mode: channel A first, then channel B
// - count mode: each B match above one decrements; break on match at one
module break_condition_control
    import brk_pkg::*;
(
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic cyc_valid_i,
    input wire logic cyc_dma_i,
    input wire logic cyc_fetch_i,
    input wire logic cyc_write_i,
    input wire logic [1:0] cyc_size_i,
    input wire logic a_cond_i,
    input wire logic a_asid_match_i,
    input wire logic b_addr_match_i,
    input wire logic b_data_match_i,
    input wire logic b_asid_match_i,
    output logic break_o,
    output logic break_after_o,
    output logic pc_trace_en_o,
    output logic irq_o
);
    // ******************************************
    // state
    // ******************************************
    typedef struct packed {
        logic [7:0] qual;
        logic [31:0] ctrl;
        logic [11:0] count;
        logic [2:0] stat;
        logic [2:0] mask;
        logic armed;
        logic brk;
        logic after;
        logic irq;
        logic rdy;
        logic err;
        logic [31:0] rdata;
    } state_t;

    state_t q;
    state_t d;

    cycle_match_if cyc_if ();

    logic mapped;
    logic [31:0] rd_val;
    logic acc;
    logic wr;
    logic rd_stat;
    logic a_hit;
    logic b_hit;
    logic b_eff;
    logic b_fire;
    logic fire;
    logic [3:0] flag_set;
    logic [3:0] flag_keep;

    // ******************************************
    // cycle qualifier check
    // ******************************************
    assign cyc_if.valid = cyc_valid_i;
    assign cyc_if.dma = cyc_dma_i;
    assign cyc_if.fetch = cyc_fetch_i;
    assign cyc_if.write = cyc_write_i;
    assign cyc_if.size = cyc_size_i;
    assign cyc_if.qual = q.qual;

    cycle_qualifier_match u_match
    (
        .cyc(cyc_if.chk)
    );

    // ******************************************
    // channel conditions
    // ******************************************
    // asid mask set means the asid comparator is not consulted
    assign a_hit = a_cond_i && (q.ctrl[C_ASID_MASK_A] || a_asid_match_i);
    assign b_hit = cyc_if.hit && b_addr_match_i
        && (!q.ctrl[C_DATA_EN_B] || b_data_match_i)
        && (q.ctrl[C_ASID_MASK_B] || b_asid_match_i);
    // in sequence mode B only counts once A has been seen earlier
    assign b_eff = b_hit && (!q.ctrl[C_SEQ] || q.armed);
    // count of zero with counting on breaks at once, no wrap
    assign b_fire = b_eff && (!q.ctrl[C_EXEC_EN] || q.count <= COUNT_ONE);
    assign fire = b_fire || (a_hit && !q.ctrl[C_SEQ]);
    assign flag_set = {a_hit && !cyc_dma_i, b_hit && !cyc_dma_i,
        a_hit && cyc_dma_i, b_hit && cyc_dma_i};

    // ******************************************
    // bus decode
    // ******************************************
    assign mapped = paddr_i == OFS_QUAL || paddr_i == OFS_CTRL || paddr_i == OFS_COUNT
        || paddr_i == OFS_STAT || paddr_i == OFS_MASK;
    assign rd_val = paddr_i == OFS_QUAL ? {24'h000000, q.qual}
        : paddr_i == OFS_CTRL ? q.ctrl
        : paddr_i == OFS_COUNT ? {20'h00000, q.count}
        : paddr_i == OFS_STAT ? {29'h00000000, q.stat}
        : paddr_i == OFS_MASK ? {29'h00000000, q.mask}
        : 32'h0000_0000;
    // the access edge is the one at which pready is seen high
    assign acc = psel_i && penable_i && q.rdy;
    assign wr = acc && pwrite_i && mapped;
    assign rd_stat = acc && !pwrite_i && paddr_i == OFS_STAT;
    assign flag_keep = (wr && paddr_i == OFS_CTRL) ? pwdata_i[C_FLAG_CPU_A:C_FLAG_DMA_B]
        : 4'hf;

    // ******************************************
    // next state
    // ******************************************
    always_comb
    begin
        d = q;
        d.rdy = psel_i && penable_i && !q.rdy;
        if (psel_i && penable_i && !q.rdy)
        begin
            d.rdata = rd_val;
            d.err = !mapped;
        end
        if (wr && paddr_i == OFS_QUAL)
        begin
            d.qual = pwdata_i[7:0];
        end
        if (wr && paddr_i == OFS_CTRL)
        begin
            // reserved bits dropped so they always read zero
            d.ctrl = pwdata_i & CTRL_WMASK;
        end
        // a match in the clearing cycle still leaves the flag set
        d.ctrl[C_FLAG_CPU_A:C_FLAG_DMA_B] =
            (q.ctrl[C_FLAG_CPU_A:C_FLAG_DMA_B] & flag_keep) | flag_set;
        if (wr && paddr_i == OFS_MASK)
        begin
            d.mask = pwdata_i[2:0];
        end
        if (!q.ctrl[C_SEQ])
        begin
            d.armed = 1'b0;
        end
        else
        begin
            if (b_fire)
            begin
                d.armed = 1'b0;
            end
            if (a_hit)
            begin
                d.armed = 1'b1;
            end
        end
        if (q.ctrl[C_EXEC_EN] && b_eff && q.count > COUNT_ONE)
        begin
            d.count = q.count - COUNT_ONE;
        end
        // a software write of the count overrides the decrement
        if (wr && paddr_i == OFS_COUNT)
        begin
            d.count = pwdata_i[11:0];
        end
        d.brk = fire;
        // channel B timing applies when B is what fired
        if (fire)
        begin
            d.after = b_fire ? q.ctrl[C_AFTER_B] : q.ctrl[C_AFTER_A];
        end
        // only bits the read returned are cleared, so a late event survives
        d.stat = (rd_stat ? (q.stat & ~q.rdata[2:0]) : q.stat) | {b_hit, a_hit, fire};
        d.irq = |(d.stat & d.mask);
    end

    // ******************************************
    // registers
    // ******************************************
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            q.qual <= QUAL_RST;
            q.ctrl <= CTRL_RST;
            q.count <= COUNT_RST;
            q.stat <= IRQ_RST;
            q.mask <= IRQ_RST;
            q.armed <= 1'b0;
            q.brk <= 1'b0;
            q.after <= 1'b0;
            q.irq <= 1'b0;
            q.rdy <= 1'b0;
            q.err <= 1'b0;
            q.rdata <= 32'h0000_0000;
        end
        else
        begin
            q <= d;
        end
    end

    assign prdata_o = q.rdata;
    assign pready_o = q.rdy;
    assign pslverr_o = q.err;
    assign break_o = q.brk;
    assign break_after_o = q.after;
    assign pc_trace_en_o = q.ctrl[C_PC_TRACE];
    assign irq_o = q.irq;

    // ******************************************
    // checks
    // ******************************************
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);

    AST_QUAL_RSVD: assert property (
        psel_i && penable_i && pready_o && !pwrite_i && paddr_i == OFS_QUAL
        |-> prdata_o[31:8] == 24'h000000)
        else $error("qualifier reserved bits read nonzero");

    AST_CTRL_RSVD: assert property (
        psel_i && penable_i && pready_o && !pwrite_i && paddr_i == OFS_CTRL
        |-> (prdata_o & ~CTRL_WMASK) == 32'h0000_0000)
        else $error("control read-only bits read nonzero");

    AST_FLAG_SET: assert property (
        a_cond_i && a_asid_match_i && !cyc_dma_i |=> q.ctrl[C_FLAG_CPU_A])
        else $error("cpu flag a not set by match");

    AST_FLAG_STICKY: assert property (
        q.ctrl[C_FLAG_DMA_B] && !(wr && paddr_i == OFS_CTRL)
        |=> q.ctrl[C_FLAG_DMA_B])
        else $error("dma flag b dropped without a write");

    AST_SEQ_WAIT_A: assert property (
        q.ctrl[C_SEQ] && !q.armed |=> !break_o)
        else $error("sequence break before channel a");

    AST_INDEP_A: assert property (
        !q.ctrl[C_SEQ] && a_hit |=> break_o)
        else $error("independent channel a did not break");

    AST_COUNT_DEC: assert property (
        q.ctrl[C_EXEC_EN] && b_eff && q.count > COUNT_ONE && !wr && !a_hit
        |=> q.count == $past(q.count) - COUNT_ONE && !break_o)
        else $error("count did not step down");

    AST_QUAL_NONE: assert property (
        q.qual == QUAL_RST && cyc_valid_i |-> cyc_if.hit)
        else $error("empty qualifier rejected a cycle");

    AST_IRQ_LEVEL: assert property (
        fire && q.mask[I_BREAK] && !rd_stat && !(wr && paddr_i == OFS_MASK)
        |=> irq_o ##1 (irq_o || !(q.stat[I_BREAK] && q.mask[I_BREAK])))
        else $error("masked-in break did not hold irq");

    AST_QUAL_WRITE: assert property (
        wr && paddr_i == OFS_QUAL
        |=> {24'h000000, q.qual} == ($past(pwdata_i) & 32'h0000_00ff))
        else $error("qualifier write did not land");

    AST_MASTER_DMA: assert property (
        q.qual[Q_MASTER +: 2] == SEL_DMA && !cyc_dma_i
        |-> !cyc_if.hit)
        else $error("dma select matched a cpu cycle");

    AST_MASTER_CPU: assert property (
        q.qual[Q_MASTER] && cyc_dma_i
        |-> !cyc_if.hit)
        else $error("cpu select matched a dma cycle");

    AST_ACCESS_FETCH: assert property (
        q.qual[Q_ACCESS +: 2] == SEL_FETCH && !cyc_fetch_i
        |-> !cyc_if.hit)
        else $error("fetch select matched a data cycle");

    AST_DIR_WRITE: assert property (
        q.qual[Q_DIR +: 2] == SEL_WRITE && !cyc_write_i
        |-> !cyc_if.hit)
        else $error("write select matched a read cycle");

    AST_SIZE_SEL: assert property (
        q.qual[Q_SIZE +: 2] != SEL_NONE && q.qual[Q_SIZE +: 2] != cyc_size_i
        |-> !cyc_if.hit)
        else $error("size select matched another size");

    AST_CTRL_WRITE: assert property (
        wr && paddr_i == OFS_CTRL
        |=> (q.ctrl & ~32'h0000_f000) == ($past(pwdata_i) & CTRL_WMASK & ~32'h0000_f000))
        else $error("control write did not land");

    AST_AFTER_A: assert property (
        fire && !b_fire && q.ctrl[C_AFTER_A]
        |=> break_after_o)
        else $error("channel a after-execution timing lost");

    AST_DATA_EN: assert property (
        q.ctrl[C_DATA_EN_B] && !b_data_match_i && !a_hit
        |=> !break_o)
        else $error("data compare enable ignored");

    AST_ASID_B: assert property (
        !q.ctrl[C_ASID_MASK_B] && !b_asid_match_i
        |-> !b_hit)
        else $error("channel b asid not checked");

    AST_FLAG_NO_SET: assert property (
        !q.ctrl[C_FLAG_CPU_A] && !flag_set[3]
        |=> !q.ctrl[C_FLAG_CPU_A])
        else $error("cpu flag a set without a match");

    AST_FLAG_CLEAR: assert property (
        wr && paddr_i == OFS_CTRL && !pwdata_i[C_FLAG_DMA_B] && !flag_set[0]
        |=> !q.ctrl[C_FLAG_DMA_B])
        else $error("dma flag b not cleared by write");

    AST_COUNT_FIRE: assert property (
        q.ctrl[C_EXEC_EN] && b_eff && q.count <= COUNT_ONE
        |=> break_o)
        else $error("count at one did not break");

    AST_STAT_STICKY: assert property (
        q.stat[I_BREAK] && !rd_stat
        |=> q.stat[I_BREAK])
        else $error("break status dropped without a read");
endmodule

// ==== rtl/brk_pkg.sv ====
// Purpose: constants for the channel B cycle qualifier and break control
// Assumes: APB register map with one aligned 32-bit word per register
// Notes: offsets 0x08 to 0x10 hold count, irq status and irq mask
package brk_pkg;
    // ******************************************
    // register offsets
    // ******************************************
    localparam logic [7:0] OFS_QUAL = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0c;
    localparam logic [7:0] OFS_MASK = 8'h10;
    // ******************************************
    // reset values and writable masks
    // ******************************************
    localparam logic [7:0] QUAL_RST = 8'h00;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK = 32'h0030_fcc9;
    localparam logic [11:0] COUNT_RST = 12'h000;
    localparam logic [11:0] COUNT_ONE = 12'h001;
    localparam logic [2:0] IRQ_RST = 3'h0;
    // ******************************************
    // qualifier fields
    // ******************************************
    localparam int Q_MASTER = 6;
    localparam int Q_ACCESS = 4;
    localparam int Q_DIR = 2;
    localparam int Q_SIZE = 0;
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_DMA = 2'h2;
    localparam logic [1:0] SEL_FETCH = 2'h1;
    localparam logic [1:0] SEL_DATA = 2'h2;
    localparam logic [1:0] SEL_READ = 2'h1;
    localparam logic [1:0] SEL_WRITE = 2'h2;
    localparam logic [1:0] SEL_BOTH = 2'h3;
    // ******************************************
    // control bit positions
    // ******************************************
    localparam int C_ASID_MASK_A = 21;
    localparam int C_ASID_MASK_B = 20;
    localparam int C_FLAG_CPU_A = 15;
    localparam int C_FLAG_DMA_B = 12;
    localparam int C_PC_TRACE = 11;
    localparam int C_AFTER_A = 10;
    localparam int C_DATA_EN_B = 7;
    localparam int C_AFTER_B = 6;
    localparam int C_SEQ = 3;
    localparam int C_EXEC_EN = 0;
    // ******************************************
    // interrupt status bits
    // ******************************************
    localparam int I_BREAK = 0;
    localparam int I_HIT_A = 1;
    localparam int I_HIT_B = 2;
endpackage

// ==== rtl/cycle_match_if.sv ====
// Purpose: carries one observed bus cycle and the channel B qualifier
// Assumes: attributes valid in the cycle that valid is high
// Notes: size code 01 byte, 10 word, 11 longword
`timescale 1ns/1ps
interface cycle_match_if;
    logic valid;
    logic dma;
    logic fetch;
    logic write;
    logic [1:0] size;
    logic [7:0] qual;
    logic hit;
    modport src
    (
        output valid, dma, fetch, write, size, qual,
        input hit
    );
    modport chk
    (
        input valid, dma, fetch, write, size, qual,
        output hit
    );
endinterface

// ==== rtl/cycle_qualifier_match.sv ====
// Purpose: checks one bus cycle against the channel B qualifier fields
// Assumes: purely combinational, no state
// Notes: a field at its no-comparison code always agrees
`timescale 1ns/1ps
module cycle_qualifier_match
    import brk_pkg::*;
(
    cycle_match_if.chk cyc
);
    logic [1:0] m;
    logic [1:0] a;
    logic [1:0] r;
    logic [1:0] s;
    logic ok_m;
    logic ok_a;
    logic ok_r;
    logic ok_s;
    assign m = cyc.qual[Q_MASTER +: 2];
    assign a = cyc.qual[Q_ACCESS +: 2];
    assign r = cyc.qual[Q_DIR +: 2];
    assign s = cyc.qual[Q_SIZE +: 2];
    always_comb
    begin
        // bit 6 set means cpu whatever bit 7 says
        ok_m = (m == SEL_NONE) || (m[0] && !cyc.dma) || (m == SEL_DMA && cyc.dma);
        ok_a = (a == SEL_NONE) || (a == SEL_BOTH) || (a == SEL_FETCH && cyc.fetch)
            || (a == SEL_DATA && !cyc.fetch);
        ok_r = (r == SEL_NONE) || (r == SEL_BOTH) || (r == SEL_READ && !cyc.write)
            || (r == SEL_WRITE && cyc.write);
        ok_s = (s == SEL_NONE) || (s == cyc.size);
        cyc.hit = cyc.valid && ok_m && ok_a && ok_r && ok_s;
    end
endmodule

// ==== test/bus_cycle_model.sv ====
// Purpose: far side model, observed bus cycles and comparator hits
// Assumes: one cycle per call, launched right after a rising edge
// Notes: idle attributes inverted, hits low, so stale values never match
`timescale 1ns/1ps
module bus_cycle_model
(
    input wire logic mclk_i,
    output logic [10:0] cyc_o
);
    // ********************
    // cycle drive
    // ********************
    initial cyc_o = 11'h000;
    // v: dma fetch write size[1:0] a_cond a_asid b_addr b_data b_asid
    task automatic run(input logic [9:0] v);
        @(posedge mclk_i);
        cyc_o <= {1'b1, v};
        @(posedge mclk_i);
        cyc_o <= {1'b0, ~v[9:5], 5'h00};
    endtask
endmodule

// ==== test/break_condition_control_test.sv ====
// Purpose: self-checking bench for the break control block
// Assumes: apb slave answers in its own time, bench waits for pready
// Notes: read and break expectations queued, checked by a monitor
`timescale 1ns/1ps
module break_condition_control_test
    import brk_pkg::*;
;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, break_o, break_after_o, pc_trace_en_o, irq_o;
    logic [10:0] cyc;
    logic [33:0] rq[$];
    logic bq[$];
    logic [33:0] e;
    logic seen = 1'b0;
    logic [31:0] rs = 32'h0000_0058;
    logic [31:0] r;
    logic [7:0] q;
    logic [9:0] v;
    int fail_count = 0;
    int n_tests = 0;
    always #10 mclk_i = ~mclk_i;
    bus_cycle_model bm (.mclk_i(mclk_i), .cyc_o(cyc));
    break_condition_control dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .cyc_valid_i(cyc[10]), .cyc_dma_i(cyc[9]), .cyc_fetch_i(cyc[8]),
        .cyc_write_i(cyc[7]), .cyc_size_i(cyc[6:5]), .a_cond_i(cyc[4]),
        .a_asid_match_i(cyc[3]), .b_addr_match_i(cyc[2]), .b_data_match_i(cyc[1]),
        .b_asid_match_i(cyc[0]), .break_o(break_o), .break_after_o(break_after_o),
        .pc_trace_en_o(pc_trace_en_o), .irq_o(irq_o));
    // ********************
    // helpers
    // ********************
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (x !== g)
        begin
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
            fail_count++;
        end
    endtask
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    // expected channel B cycle match from the qualifier fields
    function automatic logic qm(input logic [7:0] f, input logic [9:0] c);
        logic m;
        m = (f[7:6] == 2'h0) || (f[6] ? !c[9] : c[9]);
        m = m && (f[5:4] != 2'h1 || c[8]) && (f[5:4] != 2'h2 || !c[8]);
        m = m && (f[3:2] != 2'h1 || !c[7]) && (f[3:2] != 2'h2 || c[7]);
        return m && (f[1:0] == 2'h0 || f[1:0] == c[6:5]);
    endfunction
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic er, input logic [31:0] x);
        rq.push_back({~w, er, x});
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        @(posedge mclk_i);
        while (pready_o !== 1'b1)
            @(posedge mclk_i);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0, 32'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, 1'b0, x);
    endtask
    task automatic cy(input logic [9:0] c, input logic b);
        bq.push_back(b);
        bm.run(c);
    endtask
    // ********************
    // monitor
    // ********************
    always @(posedge mclk_i)
    begin
        if (pready_o === 1'b1)
        begin
            e = rq.pop_front();
            cmp("pslverr", {31'h0, e[32]}, {31'h0, pslverr_o});
            if (e[33])
                cmp("prdata", e[31:0], prdata_o);
        end
        if (seen)
            cmp("break", {31'h0, bq.pop_front()}, {31'h0, break_o});
        seen <= cyc[10];
    end
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        fail_count++;
        end_sim();
    end
    // ********************
    // scenarios
    // ********************
    initial
    begin
        repeat (10) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        rd(OFS_QUAL, 32'h0);
        rd(OFS_CTRL, CTRL_RST);
        wr(OFS_QUAL, 32'hffff_ffff);
        rd(OFS_QUAL, 32'h0000_00ff);
        wr(OFS_CTRL, 32'h003f_ffff);
        rd(OFS_CTRL, 32'h0030_0cc9);
        repeat (2) @(posedge mclk_i);
        cmp("pc_trace", 32'h1, {31'h0, pc_trace_en_o});
        repeat (4)
        begin
            r = rnd() & 32'h003f_ffff;
            wr(OFS_CTRL, r);
            rd(OFS_CTRL, r & 32'h0030_0cc9);
        end
        wr(OFS_COUNT, 32'hffff_ffff);
        rd(OFS_COUNT, 32'h0000_0fff);
        apb(1'b0, 8'h20, 32'h0, 1'b1, 32'h0);
        // interrupt raised, masked, cleared by status read
        wr(OFS_QUAL, 32'h0);
        wr(OFS_CTRL, 32'h0010_0000);
        wr(OFS_MASK, 32'h1);
        cy(10'h024, 1'b1);
        cy(10'h224, 1'b1);
        repeat (2) @(posedge mclk_i);
        cmp("irq", 32'h1, {31'h0, irq_o});
        wr(OFS_MASK, 32'h0);
        repeat (2) @(posedge mclk_i);
        cmp("irq", 32'h0, {31'h0, irq_o});
        cmp("pc_trace", 32'h0, {31'h0, pc_trace_en_o});
        wr(OFS_MASK, 32'h1);
        rd(OFS_STAT, 32'h5);
        repeat (2) @(posedge mclk_i);
        cmp("irq", 32'h0, {31'h0, irq_o});
        rd(OFS_CTRL, 32'h0010_5000);
        wr(OFS_CTRL, 32'h0010_0000);
        rd(OFS_CTRL, 32'h0010_0000);
        repeat (24)
        begin
            r = rnd();
            q = r[7:0];
            r = rnd();
            v = {r[2:0], (r[4:3] == 2'h0) ? 2'h1 : r[4:3], 5'h04};
            wr(OFS_QUAL, {24'h0, q});
            cy(v, qm(q, v));
        end
        wr(OFS_QUAL, 32'h0);
        wr(OFS_CTRL, 32'h0010_0080);
        cy(10'h024, 1'b0);
        cy(10'h026, 1'b1);
        wr(OFS_CTRL, 32'h0010_0040);
        cy(10'h124, 1'b1);
        repeat (2) @(posedge mclk_i);
        cmp("break_after", 32'h1, {31'h0, break_after_o});
        wr(OFS_CTRL, 32'h0);
        cy(10'h030, 1'b0);
        cy(10'h038, 1'b1);
        cy(10'h024, 1'b0);
        cy(10'h025, 1'b1);
        wr(OFS_CTRL, 32'h0020_0000);
        cy(10'h030, 1'b1);
        repeat (2) @(posedge mclk_i);
        cmp("break_after", 32'h0, {31'h0, break_after_o});
        wr(OFS_CTRL, 32'h0020_0400);
        cy(10'h030, 1'b1);
        repeat (2) @(posedge mclk_i);
        cmp("break_after", 32'h1, {31'h0, break_after_o});
        wr(OFS_CTRL, 32'h0030_0008);
        cy(10'h024, 1'b0);
        cy(10'h030, 1'b0);
        cy(10'h024, 1'b1);
        wr(OFS_CTRL, 32'h0030_0001);
        wr(OFS_COUNT, 32'h3);
        cy(10'h024, 1'b0);
        cy(10'h024, 1'b0);
        cy(10'h024, 1'b1);
        cy(10'h024, 1'b1);
        rd(OFS_COUNT, 32'h1);
        repeat (3) @(posedge mclk_i);
        end_sim();
    end
endmodule
